/* File: sd_rx_pkg.sv */
/*
 * Shared constants and types for the sigma-delta bit-stream receiver:
 * clock division, decimation, code limits and the sample carrier.
 * Assumes a single 25 MHz master clock domain.
 */
package sd_rx_pkg;

    // Master clock rate in Hz
    localparam int unsigned MCLK_HZ      = 25_000_000;
    // Bit-stream clock is the master clock divided by sixteen
    localparam int unsigned BIT_DIV      = 16;
    localparam int unsigned BIT_DIV_W    = $clog2(BIT_DIV);
    // Sample rate constant in samples per second; unused, the decimator gives about 12.2 kSPS
    localparam int unsigned OUT_SPS      = 8_000;
    // Bits averaged per output word: 1.5625 MHz / 128 is about 12.2 kSPS
    localparam int unsigned DEC_RATIO    = 128;
    localparam int unsigned DEC_W        = $clog2(DEC_RATIO);
    // Integrator width: 1 + 3 * log2(128) = 22, kept with margin
    localparam int unsigned ACC_W        = 26;
    // Channels per front-end chip: current, first and second voltage
    localparam int unsigned NUM_CH       = 3;
    localparam int unsigned CH_W         = 2;
    // Output code width and limits
    localparam int unsigned CODE_W       = 24;
    localparam logic [CODE_W-1:0] CODE_MAX = 24'h7F_FFFF;
    localparam logic [CODE_W-1:0] CODE_MIN = 24'h80_0000;
    // Scale from filter gain 2^21 up to 24-bit range
    localparam int unsigned CODE_SHIFT   = 2;
    // Divider phase at which the bit clock falls and data is taken
    localparam logic [BIT_DIV_W-1:0] PH_FALL = 4'h8;
    localparam logic [BIT_DIV_W-1:0] PH_TAKE = 4'hF;
    // Channel indices
    localparam logic [CH_W-1:0] CH_CURRENT = 2'h0;
    localparam logic [CH_W-1:0] CH_VOLT1   = 2'h1;
    localparam logic [CH_W-1:0] CH_VOLT2   = 2'h2;

    // One filtered word leaving the receiver
    typedef struct packed {
        logic [CH_W-1:0]   chan;
        logic              sat;
        logic              lost;
        logic [CODE_W-1:0] code;
    } sample_t;

    localparam int unsigned SAMPLE_W = $bits(sample_t);

endpackage

/* File: sd_rx_buffer.sv */
/*
 * Two-entry buffer with valid and ready on both sides.
 * Head entry sits in its own register so the output is a flop.
 * Assumes the sink may hold ready low for any number of cycles.
 */
`timescale 1ns/1ps
module sd_rx_buffer #(
    parameter int unsigned WIDTH = 8
) (
    // Clock and reset
    input  wire logic             mclk,
    input  wire logic             resetn,
    // Filling side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // Draining side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);

    logic [WIDTH-1:0] slot_q [2];
    logic [1:0]       cnt_q;
    logic [1:0]       cnt_d;
    logic             valid_q;
    logic             push;
    logic             pop;

    // Ready drops only when both slots are taken
    assign in_ready  = (cnt_q != 2'd2);
    assign push      = in_valid && in_ready;
    assign pop       = valid_q && out_ready;
    assign out_valid = valid_q;
    assign out_data  = slot_q[0];

    // Next fill level
    always_comb begin
        cnt_d = cnt_q;
        if (push && !pop) begin
            cnt_d = cnt_q + 2'd1;
        end else if (pop && !push) begin
            cnt_d = cnt_q - 2'd1;
        end
    end

    // Fill level; valid is its own flop so the port is registered
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            cnt_q   <= 2'd0;
            valid_q <= 1'b0;
        end else begin
            cnt_q   <= cnt_d;
            valid_q <= (cnt_d != 2'd0);
        end
    end

    // Storage shifts toward the head on pop
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            slot_q[0] <= '0;
            slot_q[1] <= '0;
        end else if (pop) begin
            slot_q[0] <= (cnt_q == 2'd2) ? slot_q[1] : in_data;
            if (push && cnt_q == 2'd2) begin
                slot_q[1] <= in_data;
            end
        end else if (push) begin
            if (cnt_q == 2'd0) begin
                slot_q[0] <= in_data;
            end else begin
                slot_q[1] <= in_data;
            end
        end
    end

endmodule

/* File: sd_rx_top.sv */
/*
 * Sigma-delta bit-stream receiver: drives the bit-stream clock, takes
 * one bit per period from each front-end data pin and averages the
 * streams in a third-order decimation filter into 24-bit signed words.
 * Assumes data pins are asynchronous and the front end changes data
 * on the rising edge of the bit-stream clock.
 */
// Overview of operation
// - Modulators sample at master clock over sixteen, 1.5625 MHz nominal.
// - Each stream carries one bit per sampling period, ones and zeros.
// - Each bit is a one-bit feedback level, weighted plus or minus one.
// - Low-pass filter averages bits into 24-bit words after isolation.
// - Data pins are timed by the bit clock this receiver drives.
// - Nominal full scale yields about 5,320,000, varying per chip.
// - Inputs beyond full scale may overflow the filter; flagged here.
// - A full chip gives one current and two voltage streams.
// - Reduced chip has no second voltage stream; receiver skips it.
// - Non-isolated chip uses the same stream and filter arrangement.
`timescale 1ns/1ps
module sd_rx_top (
    // Clock and reset
    input  wire logic                            mclk,
    input  wire logic                            resetn,
    // Front-end link
    output logic                                 bit_clk,
    input  wire logic [sd_rx_pkg::NUM_CH-1:0]    data_pin,
    // Strap: high when the second voltage stream exists
    input  wire logic                            volt2_present,
    // Sample stream
    output logic                                 out_valid,
    input  wire logic                            out_ready,
    output sd_rx_pkg::sample_t                   out_data
);
    import sd_rx_pkg::*;

    logic [BIT_DIV_W-1:0] div_q;
    logic                 bit_clk_q;
    logic                 take;
    logic [DEC_W-1:0]     dec_q;
    logic                 dump;
    logic [NUM_CH-1:0]    sync1_q;
    logic [NUM_CH-1:0]    sync2_q;
    logic                 v2_s1_q;
    logic                 v2_s2_q;
    logic [NUM_CH-1:0]    pend_q;
    logic                 push_fire;
    sample_t              word_q [NUM_CH];
    sample_t              push_word;
    logic                 push_valid;
    logic                 push_ready;
    logic [CH_W-1:0]      pick;
    logic [NUM_CH-1:0]    ch_on;

    // Divide master clock by sixteen for the bit-stream clock
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            div_q <= '0;
        end else begin
            div_q <= div_q + 1'b1;
        end
    end

    // Bit clock high for the first half period, low for the second
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            bit_clk_q <= 1'b0;
        end else if (div_q == (BIT_DIV_W)'(BIT_DIV - 1)) begin
            bit_clk_q <= 1'b1;
        end else if (div_q == PH_FALL - 1'b1) begin
            bit_clk_q <= 1'b0;
        end
    end
    assign bit_clk = bit_clk_q;

    // Two-flop synchronisers on data pins and the strap
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            sync1_q <= '0;
            sync2_q <= '0;
            v2_s1_q <= 1'b0;
            v2_s2_q <= 1'b0;
        end else begin
            sync1_q <= data_pin;
            sync2_q <= sync1_q;
            v2_s1_q <= volt2_present;
            v2_s2_q <= v2_s1_q;
        end
    end

    // Take late in the low half, well after data settles past sync delay
    assign take = (div_q == PH_TAKE);

    // Decimation counter: one word per 128 bits, about 12.2 kSPS
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            dec_q <= '0;
        end else if (take) begin
            dec_q <= dec_q + 1'b1;
        end
    end
    assign dump = take && (dec_q == (DEC_W)'(DEC_RATIO - 1));

    // Reduced chip: second voltage stream simply never reported
    assign ch_on = {v2_s2_q, 2'b11};

    // Third-order integrate-and-dump filter, one per stream
    genvar g;
    generate
        for (g = 0; g < NUM_CH; g++) begin : g_ch
            logic signed [ACC_W-1:0] i1_q, i2_q, i3_q;
            logic signed [ACC_W-1:0] z1_q, z2_q, z3_q;
            logic signed [ACC_W-1:0] d1, d2, d3;
            logic signed [ACC_W-1:0] x;
            logic signed [ACC_W-1:0] scaled;
            logic                    hi;
            logic                    lo;

            // Bit one feeds back +1, bit zero feeds back -1
            assign x = sync2_q[g] ? ACC_W'(1) : -ACC_W'(1);

            // Integrators run at the bit rate; wrap is harmless
            always_ff @(posedge mclk or negedge resetn) begin
                if (!resetn) begin
                    i1_q <= '0;
                    i2_q <= '0;
                    i3_q <= '0;
                end else if (take) begin
                    i1_q <= i1_q + x;
                    i2_q <= i2_q + i1_q;
                    i3_q <= i3_q + i2_q;
                end
            end

            // Combs at the word rate
            assign d1 = i3_q - z1_q;
            assign d2 = d1 - z2_q;
            assign d3 = d2 - z3_q;
            always_ff @(posedge mclk or negedge resetn) begin
                if (!resetn) begin
                    z1_q <= '0;
                    z2_q <= '0;
                    z3_q <= '0;
                end else if (dump) begin
                    z1_q <= i3_q;
                    z2_q <= d1;
                    z3_q <= d2;
                end
            end

            // Gain 2^21 scaled to 24 bits; all-ones input tops out
            assign scaled = d3 <<< CODE_SHIFT;
            assign hi = scaled > $signed({{(ACC_W-CODE_W){1'b0}}, CODE_MAX});
            assign lo = scaled < $signed({{(ACC_W-CODE_W){1'b1}}, CODE_MIN});

            // Saturate rather than wrap, and flag it
            always_ff @(posedge mclk or negedge resetn) begin
                if (!resetn) begin
                    word_q[g] <= '0;
                end else if (dump) begin
                    word_q[g].chan <= CH_W'(g);
                    word_q[g].sat  <= hi || lo;
                    // A word drained in this same cycle was not lost
                    word_q[g].lost <= pend_q[g] &&
                                      !(push_fire && pick == CH_W'(g));
                    word_q[g].code <= hi ? CODE_MAX :
                                      lo ? CODE_MIN :
                                      scaled[CODE_W-1:0];
                end
            end
        end
    endgenerate

    // Lowest pending channel goes first into the buffer
    always_comb begin
        pick = CH_CURRENT;
        if (pend_q[CH_CURRENT]) begin
            pick = CH_CURRENT;
        end else if (pend_q[CH_VOLT1]) begin
            pick = CH_VOLT1;
        end else if (pend_q[CH_VOLT2]) begin
            pick = CH_VOLT2;
        end
    end
    assign push_valid = |pend_q;
    assign push_word  = word_q[pick];

    // Pending words; a new dump wins over the drain of the same slot
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            pend_q <= '0;
        end else begin
            for (int c = 0; c < NUM_CH; c++) begin
                if (dump && ch_on[c]) begin
                    pend_q[c] <= 1'b1;
                end else if (push_fire && pick == CH_W'(c)) begin
                    pend_q[c] <= 1'b0;
                end
            end
        end
    end

    // One word enters the buffer this cycle
    assign push_fire = push_valid && push_ready;

    // Stall by the sink holds up to two words here; a longer stall overwrites pending words and flags them lost
    sd_rx_buffer #(
        .WIDTH (SAMPLE_W)
    ) u_buf (
        .mclk      (mclk),
        .resetn    (resetn),
        .in_valid  (push_valid),
        .in_ready  (push_ready),
        .in_data   (push_word),
        .out_valid (out_valid),
        .out_ready (out_ready),
        .out_data  (out_data)
    );

endmodule

/* File: sd_rx_asserts.sv */
/*
 * Checker for the bit-stream receiver top, bound beside every instance.
 * Assumes one mclk domain with an asynchronous active-low reset.
 */
`timescale 1ns/1ps
module sd_rx_asserts
    import sd_rx_pkg::*;
(
    // Clock and reset
    input wire logic              mclk,
    input wire logic              resetn,
    // Front-end link
    input wire logic              bit_clk,
    input wire logic [NUM_CH-1:0] data_pin,
    input wire logic              volt2_present,
    // Sample stream
    input wire logic              out_valid,
    input wire logic              out_ready,
    input wire sample_t           out_data
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);

    logic [11:0] up_q;
    logic [11:0] v2_q;
    logic        seen_q;
    // Saturating counts; a stall clears v2_q since stale words may wait
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            up_q <= 12'h000;
            v2_q <= 12'h000;
            seen_q <= 1'b0;
        end else begin
            if (up_q != 12'hFFF) up_q <= up_q + 12'h001;
            if (out_valid) seen_q <= 1'b1;
            if (volt2_present || (out_valid && !out_ready)) v2_q <= 12'h000;
            else if (v2_q != 12'hFFF) v2_q <= v2_q + 12'h001;
        end
    end

    sequence s_high8; bit_clk [*8]; endsequence
    sequence s_low8; !bit_clk [*8]; endsequence
    property p_bit_period;
        $rose(bit_clk) |-> s_high8 ##1 s_low8 ##1 bit_clk;
    endproperty
    a_bit_period: assert property (p_bit_period)
        else $error("bit clock not 8 high 8 low");
    property p_hold;
        out_valid && !out_ready |=> out_valid && $stable(out_data);
    endproperty
    a_hold: assert property (p_hold)
        else $error("word changed before accept");
    property p_chan; out_valid |-> out_data.chan <= CH_VOLT2; endproperty
    a_chan: assert property (p_chan)
        else $error("illegal channel index");
    property p_no_volt2;
        v2_q > 12'h960 && out_valid |-> out_data.chan != CH_VOLT2;
    endproperty
    a_no_volt2: assert property (p_no_volt2)
        else $error("absent stream produced a word");
    property p_sat;
        out_valid && out_data.sat |->
            out_data.code == CODE_MAX || out_data.code == CODE_MIN;
    endproperty
    a_sat: assert property (p_sat)
        else $error("saturated word not at a limit");
    property p_quiet; up_q < 12'h5DC |-> !out_valid; endproperty
    a_quiet: assert property (p_quiet)
        else $error("word before filter could average");
    property p_reset_idle;
        $rose(resetn) |-> (!out_valid && !bit_clk);
    endproperty
    a_reset_idle: assert property (p_reset_idle)
        else $error("outputs busy at reset release");
    property p_first_word; up_q == 12'hA8C |-> seen_q; endproperty
    a_first_word: assert property (p_first_word)
        else $error("no word within first dump period");
endmodule

bind sd_rx_top sd_rx_asserts u_chk (
    .mclk(mclk), .resetn(resetn), .bit_clk(bit_clk),
    .data_pin(data_pin), .volt2_present(volt2_present),
    .out_valid(out_valid), .out_ready(out_ready), .out_data(out_data)
);

/* File: fe_model.sv */
/*
 * Front-end converter model: one modulator stream per channel.
 * Assumes bit_clk comes from the receiver; mode picks 3 bits a channel.
 */
`timescale 1ns/1ps
module fe_model (
    // Link
    input  wire logic       bit_clk,
    input  wire logic       present2,
    input  wire logic [8:0] mode,
    output logic      [2:0] data_pin
);
    int          acc [3] = '{0, 0, 0};
    int          seed_m = 32'hA079_95DE;
    logic [31:0] r;
    initial data_pin = 3'h0;
    // New bit launched on the rising edge, one per period
    always @(posedge bit_clk) begin
        r = $random(seed_m);
        for (int c = 0; c < 3; c++) begin
            case (mode[3*c +: 3])
                3'h0: data_pin[c] <= 1'b1;
                3'h1: data_pin[c] <= 1'b0;
                3'h2: data_pin[c] <= ~data_pin[c];
                3'h3: begin
                    data_pin[c] <= acc[c] >= 0;
                    acc[c] <= acc[c] + 5320000
                        - (acc[c] >= 0 ? 8388608 : -8388608);
                end
                default: data_pin[c] <= r[c];
            endcase
        end
        // Missing stream: pin is noise, never a held level
        if (!present2) data_pin[2] <= r[5];
    end
endmodule

/* File: tb.sv */
/*
 * Self-checking bench for the receiver with a front-end model.
 * Assumes the checker is bound in by its own file.
 */
`timescale 1ns/1ps
module tb;
    import sd_rx_pkg::*;
    logic              mclk = 1'b0;
    logic              resetn = 1'b0;
    logic              volt2_present = 1'b1;
    logic              out_ready = 1'b0;
    logic              stall = 1'b0;
    logic              bit_clk;
    logic              out_valid;
    logic [NUM_CH-1:0] data_pin;
    logic [8:0]        mode = 9'h000;
    sample_t           out_data;
    sample_t           w;
    logic              any_lost;
    int mismatches = 0;
    int samples_checked = 0;
    int seed = 32'hA079_95DE;

    always #20 mclk = ~mclk;
    sd_rx_top uut (.mclk(mclk), .resetn(resetn), .bit_clk(bit_clk),
        .data_pin(data_pin), .volt2_present(volt2_present),
        .out_valid(out_valid), .out_ready(out_ready), .out_data(out_data));
    fe_model fe (.bit_clk(bit_clk), .present2(volt2_present), .mode(mode),
        .data_pin(data_pin));
    // Sink takes about three cycles in four
    always @(posedge mclk) out_ready <= !stall && ($random(seed) % 4 != 0);

    task final_report;
        $display("mismatches %0d checked %0d", mismatches, samples_checked);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    // Bounded wait for one accepted word
    task get_word(output sample_t s);
        int n;
        n = 0;
        @(posedge mclk);
        while (!(out_valid === 1'b1 && out_ready === 1'b1)) begin
            n++;
            if (n > 6000) begin
                mismatches++;
                $display("wrong value at %0t: no word accepted", $time);
                final_report;
            end
            @(posedge mclk);
        end
        s = out_data;
    endtask
    function automatic logic [23:0] exp_code(input logic [2:0] m);
        if (m == 3'h0) return CODE_MAX;
        if (m == 3'h1) return CODE_MIN;
        return 24'h00_0000;
    endfunction
    // Skip four dumps while the filter settles, then check one dump
    task run_mode(input logic [8:0] m, input int nch);
        logic [2:0] cm;
        logic signed [23:0] v;
        mode <= m;
        for (int k = 0; k < 4*nch; k++) get_word(w);
        for (int k = 0; k < nch; k++) begin
            get_word(w);
            cm = m[3*w.chan +: 3];
            v = $signed(w.code);
            chk(32'(w.chan < 2'(nch)), 32'h1);
            if (cm == 3'h3)
                chk(32'(v > 24'sh4F_A6A0 && v < 24'sh52_B3E0), 32'h1);
            else if (cm == 3'h4)
                chk(32'(v > -24'sh3D_0900 && v < 24'sh3D_0900), 32'h1);
            else begin
                chk(32'(w.code), 32'(exp_code(cm)));
                chk(32'(w.sat), 32'(cm == 3'h0));
            end
        end
    endtask

    // Watchdog: about 68k cycles expected, give up at 85k cycles of 40 ns
    initial begin
        #3_400_000;
        mismatches++;
        $display("wrong value at %0t: watchdog expired", $time);
        final_report;
    end
    initial begin
        repeat (10) @(posedge mclk);
        resetn <= 1'b1;
        run_mode({3'h2, 3'h1, 3'h0}, 3);
        run_mode({3'h0, 3'h2, 3'h1}, 3);
        run_mode({3'h3, 3'h3, 3'h3}, 3);
        run_mode({3'h4, 3'h4, 3'h4}, 3);
        volt2_present <= 1'b0;
        run_mode({3'h0, 3'h3, 3'h1}, 2);
        // Long stall overwrites pending words; drain must flag it
        stall <= 1'b1;
        repeat (6144) @(posedge mclk);
        stall <= 1'b0;
        any_lost = 1'b0;
        for (int k = 0; k < 4; k++) begin
            get_word(w);
            any_lost = any_lost | w.lost;
        end
        chk(32'(any_lost), 32'h1);
        resetn <= 1'b0;
        repeat (3) @(posedge mclk);
        resetn <= 1'b1;
        run_mode({3'h0, 3'h1, 3'h0}, 2);
        final_report;
    end
endmodule
